// ==== hw/umh_top.sv ====
// modem handshake, serial pins and strap logic of two serial ports
//
// Added by the designer: the plain strobed port and the register addresses.
`include "umh_params.svh"

module umh_top (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic [`UMH_ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]               regWriteData,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic      [7:0]               regReadData,
  output logic                          irq,
  output logic                          port1SendRequestN,
  output logic                          port1TerminalReadyN,
  output logic                          port2SendRequestNOut,
  output logic                          port2SendRequestNOe,
  input  wire logic                     port2SendRequestNIn,
  output logic                          port2TerminalReadyN,
  input  wire logic                     port1ClearToSendN,
  input  wire logic                     port1SetReadyN,
  input  wire logic                     port1CarrierDetectN,
  input  wire logic                     port1RingN,
  input  wire logic                     port2ClearToSendN,
  input  wire logic                     port2SetReadyN,
  input  wire logic                     port2CarrierDetectN,
  input  wire logic                     port2RingN,
  input  wire logic                     port1SerialIn,
  output logic                          port1SerialOut,
  input  wire logic                     port2SerialOrInfraredIn,
  output logic                          port2SerialOrInfraredOut,
  input  wire logic                     port1TxBit,
  input  wire logic                     port2TxBit,
  output logic                          port1RxBit,
  output logic                          port2RxBit,
  output logic                          configBaseStrap,
  output logic      [15:0]              configIndexBase,
  output logic      [1:0]               portModemIrq
);
  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  umh_pkg::umh_byte_t   modem_control_reg [2];
  umh_pkg::umh_byte_t   ier [2];
  umh_pkg::umh_byte_t   next_mcr [2];
  umh_pkg::umh_byte_t   next_ier [2];
  umh_pkg::umh_byte_t   modem_status_reg [2];
  logic [1:0]           irqStatus;
  logic [1:0]           irqMask;
  logic [1:0]           next_irqStatus;
  logic [1:0]           next_irqMask;
  logic [7:0]           next_readData;
  logic [1:0]           statusRead;
  logic [1:0]           changeEvent;
  logic [3:0]           modemLevel [2];
  logic [3:0]           pinLevel [2];
  logic [1:0]           loopMode;
  logic [1:0]           txBit;
  logic [1:0]           sendReqN;
  logic [1:0]           termReadyN;
  logic [1:0]           serialOut;
  logic [1:0]           rxBit;
  logic [1:0]           next_sendReqN;
  logic [1:0]           next_termReadyN;
  logic [1:0]           next_serialOut;
  logic [1:0]           next_rxBit;
  umh_pkg::umh_state_t  state;
  umh_pkg::umh_state_t  next_state;
  logic                 strap;
  logic                 next_strap;
  umh_pkg::umh_sel_t    sel;
  logic                 selPort;

  // -------------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------------
  // maps a bus address onto a register kind; port taken from address bit 3
  function automatic umh_pkg::umh_sel_t decodeSel(
    input logic [`UMH_ADDR_W-1:0] addr
  );
    umh_pkg::umh_sel_t s;
    s = umh_pkg::UMH_SEL_NONE;
    if (addr == `UMH_ADDR_IRQSTAT)
      s = umh_pkg::UMH_SEL_IRQSTAT;
    else if (addr == `UMH_ADDR_IRQMASK)
      s = umh_pkg::UMH_SEL_IRQMASK;
    else if (addr == `UMH_ADDR_CONFIG)
      s = umh_pkg::UMH_SEL_CONFIG;
    else if (addr[4] == 1'b0)
    begin
      unique case (addr[2:0])
        `UMH_OFS_IER: s = umh_pkg::UMH_SEL_IER;
        `UMH_OFS_MCR: s = umh_pkg::UMH_SEL_MCR;
        `UMH_OFS_MSR: s = umh_pkg::UMH_SEL_MSR;
        default:      s = umh_pkg::UMH_SEL_NONE;
      endcase
    end
    return s;
  endfunction : decodeSel

  assign sel     = decodeSel(regAddr);
  assign selPort = regAddr[3];

  // -------------------------------------------------------------------------
  // port side gathering
  // -------------------------------------------------------------------------
  // inverted pin levels in status order: dcd, ri, dsr, cts
  assign pinLevel[0] = ~{port1CarrierDetectN, port1RingN,
                         port1SetReadyN, port1ClearToSendN};
  assign pinLevel[1] = ~{port2CarrierDetectN, port2RingN,
                         port2SetReadyN, port2ClearToSendN};
  assign txBit       = {port2TxBit, port1TxBit};

  // loopback feeds control bits back as modem inputs
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      loopMode[p] = modem_control_reg[p][`UMH_MCR_LOOP];
      if (loopMode[p])
        modemLevel[p] = {modem_control_reg[p][`UMH_MCR_OUT2], modem_control_reg[p][`UMH_MCR_OUT1],
                         modem_control_reg[p][`UMH_MCR_DTR], modem_control_reg[p][`UMH_MCR_RTS]};
      else
        modemLevel[p] = pinLevel[p];
    end
  end

  // -------------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------------
  // bus writes to modem control and interrupt enable
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      next_mcr[p] = modem_control_reg[p];
      next_ier[p] = ier[p];
      if (regWrite && selPort == p[0])
      begin
        if (sel == umh_pkg::UMH_SEL_MCR)
          next_mcr[p] = regWriteData & `UMH_MCR_MASK;
        if (sel == umh_pkg::UMH_SEL_IER)
          next_ier[p] = regWriteData;
      end
      statusRead[p] = regRead && sel == umh_pkg::UMH_SEL_MSR
                      && selPort == p[0];
    end
  end

  // control register storage
  always_ff @(posedge clk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!reset_n)
      begin
        modem_control_reg[p] <= `UMH_RST_BYTE;
        ier[p] <= `UMH_RST_BYTE;
      end
      else
      begin
        modem_control_reg[p] <= next_mcr[p];
        ier[p] <= next_ier[p];
      end
    end
  end

  // -------------------------------------------------------------------------
  // modem status trackers
  // -------------------------------------------------------------------------
  // one tracker per port; interrupt enable bit 3 gates change reporting
  umh_modem_status uStatus1 (
    .clk         (clk),
    .reset_n     (reset_n),
    .modemLevel  (modemLevel[0]),
    .statusRead  (statusRead[0]),
    .irqEnable   (ier[0][`UMH_IER_MODEM]),
    .modem_status_reg         (modem_status_reg[0]),
    .changeIrq   (portModemIrq[0]),
    .changeEvent (changeEvent[0])
  );

  umh_modem_status uStatus2 (
    .clk         (clk),
    .reset_n     (reset_n),
    .modemLevel  (modemLevel[1]),
    .statusRead  (statusRead[1]),
    .irqEnable   (ier[1][`UMH_IER_MODEM]),
    .modem_status_reg         (modem_status_reg[1]),
    .changeIrq   (portModemIrq[1]),
    .changeEvent (changeEvent[1])
  );

  // -------------------------------------------------------------------------
  // handshake and serial pins
  // -------------------------------------------------------------------------
  // handshake outputs inverse of control bits, forced inactive in loopback
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      next_sendReqN[p]   = ~modem_control_reg[p][`UMH_MCR_RTS] | loopMode[p];
      next_termReadyN[p] = ~modem_control_reg[p][`UMH_MCR_DTR] | loopMode[p];
      // transmit path never looks at clear-to-send
      next_serialOut[p]  = txBit[p] | loopMode[p];
      next_rxBit[p]      = loopMode[p] ? txBit[p] : 1'b0;
    end
    if (!loopMode[0])
      next_rxBit[0] = port1SerialIn;
    if (!loopMode[1])
      next_rxBit[1] = port2SerialOrInfraredIn;
  end

  // pin registers, idle levels after reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sendReqN   <= 2'h3;
      termReadyN <= 2'h3;
      serialOut  <= 2'h3;
      rxBit      <= 2'h3;
    end
    else
    begin
      sendReqN   <= next_sendReqN;
      termReadyN <= next_termReadyN;
      serialOut  <= next_serialOut;
      rxBit      <= next_rxBit;
    end
  end

  assign port1SendRequestN        = sendReqN[0];
  assign port1TerminalReadyN      = termReadyN[0];
  assign port2SendRequestNOut     = sendReqN[1];
  assign port2TerminalReadyN      = termReadyN[1];
  assign port1SerialOut           = serialOut[0];
  assign port2SerialOrInfraredOut = serialOut[1];
  assign port1RxBit               = rxBit[0];
  assign port2RxBit               = rxBit[1];

  // -------------------------------------------------------------------------
  // configuration strap
  // -------------------------------------------------------------------------
  // port 2 send-request pin is an input until the first edge after reset
  always_comb
  begin
    next_state = umh_pkg::UMH_ST_RUN;
    next_strap = strap;
    unique case (state)
      umh_pkg::UMH_ST_STRAP: next_strap = port2SendRequestNIn;
      umh_pkg::UMH_ST_RUN:   next_strap = strap;
    endcase
  end

  // strap registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= umh_pkg::UMH_ST_STRAP;
      strap <= 1'b0;
    end
    else
    begin
      state <= next_state;
      strap <= next_strap;
    end
  end

  assign port2SendRequestNOe = (state == umh_pkg::UMH_ST_RUN);
  assign configBaseStrap     = strap;
  assign configIndexBase     = strap ? `UMH_CFG_BASE_HIGH
                                     : `UMH_CFG_BASE_LOW;

  // -------------------------------------------------------------------------
  // interrupt status and mask
  // -------------------------------------------------------------------------
  // sticky per-port change bits, write one to clear, set wins
  always_comb
  begin
    next_irqStatus = irqStatus;
    next_irqMask   = irqMask;
    if (regWrite && sel == umh_pkg::UMH_SEL_IRQSTAT)
      next_irqStatus = irqStatus & ~regWriteData[1:0];
    if (regWrite && sel == umh_pkg::UMH_SEL_IRQMASK)
      next_irqMask = regWriteData[1:0];
    next_irqStatus = next_irqStatus | changeEvent;
  end

  // interrupt registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irqStatus <= 2'h0;
      irqMask   <= 2'h0;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      irqMask   <= next_irqMask;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // -------------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------------
  // read data one cycle after the strobe, zero when idle or unmapped
  always_comb
  begin
    next_readData = 8'h00;
    if (regRead)
    begin
      unique case (sel)
        umh_pkg::UMH_SEL_IER:     next_readData = ier[selPort];
        umh_pkg::UMH_SEL_MCR:     next_readData = modem_control_reg[selPort];
        umh_pkg::UMH_SEL_MSR:     next_readData = modem_status_reg[selPort];
        umh_pkg::UMH_SEL_IRQSTAT: next_readData = {6'h00, irqStatus};
        umh_pkg::UMH_SEL_IRQMASK: next_readData = {6'h00, irqMask};
        umh_pkg::UMH_SEL_CONFIG:  next_readData = {7'h00, strap};
        umh_pkg::UMH_SEL_NONE:    next_readData = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      regReadData <= 8'h00;
    else
      regReadData <= next_readData;
  end
endmodule : umh_top

// ==== hw/umh_params.svh ====
// constants for the modem handshake and serial pin block
`ifndef UMH_PARAMS_SVH
`define UMH_PARAMS_SVH

// register map, byte addresses on the plain register port
`define UMH_ADDR_W       5
`define UMH_P1_BASE      5'h00
`define UMH_P2_BASE      5'h08
`define UMH_OFS_IER      3'h1
`define UMH_OFS_MCR      3'h4
`define UMH_OFS_MSR      3'h6
`define UMH_ADDR_IRQSTAT 5'h10
`define UMH_ADDR_IRQMASK 5'h11
`define UMH_ADDR_CONFIG  5'h12

// modem control fields
`define UMH_MCR_DTR  0
`define UMH_MCR_RTS  1
`define UMH_MCR_OUT1 2
`define UMH_MCR_OUT2 3
`define UMH_MCR_LOOP 4
`define UMH_MCR_MASK 8'h1f

// interrupt enable field
`define UMH_IER_MODEM 3

// modem status fields
`define UMH_MSR_DCTS 0
`define UMH_MSR_DDSR 1
`define UMH_MSR_TERI 2
`define UMH_MSR_DDCD 3
`define UMH_MSR_CTS  4
`define UMH_MSR_DSR  5
`define UMH_MSR_RI   6
`define UMH_MSR_DCD  7

// reset values
`define UMH_RST_BYTE 8'h00

// configuration index base selected by the strap
`define UMH_CFG_BASE_LOW  16'h03f0
`define UMH_CFG_BASE_HIGH 16'h0370

`endif

// ==== hw/umh_pkg.sv ====
// types for the modem handshake and serial pin block
package umh_pkg;
  typedef logic [7:0] umh_byte_t;

  // register selected by a bus address
  typedef enum logic [2:0] {
    UMH_SEL_NONE,
    UMH_SEL_IER,
    UMH_SEL_MCR,
    UMH_SEL_MSR,
    UMH_SEL_IRQSTAT,
    UMH_SEL_IRQMASK,
    UMH_SEL_CONFIG
  } umh_sel_t;

  // strap capture phase
  typedef enum logic {
    UMH_ST_STRAP,
    UMH_ST_RUN
  } umh_state_t;
endpackage : umh_pkg

// ==== hw/umh_modem_status.sv ====
// modem status tracker of one serial port
`include "umh_params.svh"

module umh_modem_status (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [3:0]       modemLevel,  // asserted levels: dcd, ri, dsr, cts
  input  wire logic             statusRead,
  input  wire logic             irqEnable,
  output umh_pkg::umh_byte_t    modem_status_reg,
  output logic                  changeIrq,
  output logic                  changeEvent
);
  logic [3:0] level;
  logic [3:0] delta;
  logic       pending;
  logic [3:0] next_level;
  logic [3:0] next_delta;
  logic       next_pending;
  logic [3:0] fell;
  logic       changed;

  // -------------------------------------------------------------------------
  // change detection
  // -------------------------------------------------------------------------
  // a pin going low-to-high is an asserted level falling; set wins over read
  always_comb
  begin
    fell         = level & ~modemLevel;
    changed      = |(level ^ modemLevel);
    next_level   = modemLevel;
    next_delta   = (statusRead ? 4'h0 : delta) | fell;
    next_pending = (statusRead ? 1'b0 : pending) | changed;
  end

  // state registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      level   <= 4'h0;
      delta   <= 4'h0;
      pending <= 1'b0;
    end
    else
    begin
      level   <= next_level;
      delta   <= next_delta;
      pending <= next_pending;
    end
  end

  // status image and interrupt
  assign modem_status_reg         = {level, delta};
  assign changeIrq   = irqEnable & pending;
  assign changeEvent = irqEnable & changed;
endmodule : umh_modem_status

// ==== testbench/umh_modem_model.sv ====
// model of the external modem and the board strap on the handshake pins
module umh_modem_model (
  input  wire logic [7:0] lvl,
  input  wire logic       strapLevel,
  input  wire logic       rtsOut,
  input  wire logic       rtsOe,
  output logic      [3:0] p1PinsN,
  output logic      [3:0] p2PinsN,
  output logic            rtsPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // asserted lines are driven low, order dcd ri dsr cts
  assign p1PinsN = ~lvl[3:0];
  assign p2PinsN = ~lvl[7:4];
  // strap resistor holds the shared pin whenever the device lets go of it
  assign rtsPin = rtsOe ? rtsOut : strapLevel;
endmodule : umh_modem_model

// ==== testbench/umh_top_checker.sv ====
// port checker of the modem handshake block and its bind
`include "umh_params.svh"
module umh_top_checker (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [`UMH_ADDR_W-1:0] regAddr,
  input wire logic [7:0]             regWriteData,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [7:0]             regReadData,
  input wire logic                   port1SendRequestN,
  input wire logic                   port1TerminalReadyN,
  input wire logic                   port2SendRequestNOut,
  input wire logic                   port2SendRequestNIn,
  input wire logic                   port2TerminalReadyN,
  input wire logic                   port1ClearToSendN,
  input wire logic                   port1SetReadyN,
  input wire logic                   port1CarrierDetectN,
  input wire logic                   port1RingN,
  input wire logic                   port1TxBit,
  input wire logic                   port1SerialOut,
  input wire logic                   configBaseStrap,
  input wire logic [15:0]            configIndexBase,
  input wire logic [1:0]             portModemIrq
);
  localparam logic [4:0] M1 = `UMH_P1_BASE + `UMH_OFS_MCR;
  localparam logic [4:0] M2 = `UMH_P2_BASE + `UMH_OFS_MCR;
  localparam logic [4:0] S1 = `UMH_P1_BASE + `UMH_OFS_MSR;
  localparam logic [4:0] E1 = `UMH_P1_BASE + `UMH_OFS_IER;
  logic       loop1, ier1, next_loop1, next_ier1;
  logic [3:0] pins1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  assign pins1 = {port1CarrierDetectN, port1RingN, port1SetReadyN, port1ClearToSendN};
  // port 1 loopback and modem interrupt enable as last written
  always_comb
  begin
    next_loop1 = loop1;
    next_ier1  = ier1;
    if (!reset_n)
    begin
      next_loop1 = 1'b0;
      next_ier1  = 1'b0;
    end
    else if (regWrite && regAddr == M1)
      next_loop1 = regWriteData[`UMH_MCR_LOOP];
    else if (regWrite && regAddr == E1)
      next_ier1 = regWriteData[`UMH_IER_MODEM];
  end
  always_ff @(posedge clk)
  begin
    loop1 <= next_loop1;
    ier1  <= next_ier1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // pins are registered from the control register, so they settle two edges after the write
  p1_follow_a: assert property (regWrite && regAddr == M1 && !regWriteData[4]
    |-> ##2 port1SendRequestN == !$past(regWriteData[1], 2) &&
    port1TerminalReadyN == !$past(regWriteData[0], 2))
    else $error("port 1 handshake pins do not follow control bits");
  p2_follow_a: assert property (regWrite && regAddr == M2 && !regWriteData[4]
    |-> ##2 port2SendRequestNOut == !$past(regWriteData[1], 2) &&
    port2TerminalReadyN == !$past(regWriteData[0], 2))
    else $error("port 2 handshake pins do not follow control bits");
  reset_idle_a: assert property (disable iff (1'b0) !reset_n |=> port1SendRequestN &&
    port1TerminalReadyN && port2TerminalReadyN && port2SendRequestNOut)
    else $error("handshake outputs not inactive after reset");
  loop_idle_a: assert property (regWrite && regAddr == M1 && regWriteData[4] |-> ##2
    port1SendRequestN && port1TerminalReadyN) else $error("loopback did not idle handshake pins");
  strap_take_a: assert property ($rose(reset_n) |=> configBaseStrap == $past(port2SendRequestNIn))
    else $error("strap not captured at reset end");
  base_map_a: assert property (configIndexBase ==
    (configBaseStrap ? `UMH_CFG_BASE_HIGH : `UMH_CFG_BASE_LOW)) else $error("index base wrong");
  cts_level_a: assert property (regRead && regAddr == S1 && !loop1 && !$past(loop1) &&
    $stable(port1ClearToSendN) |=> regReadData[4] == !$past(port1ClearToSendN))
    else $error("status bit 4 not inverse of clear-to-send");
  cts_delta_a: assert property (!loop1 && $rose(port1ClearToSendN) ##1
    (regRead && regAddr == S1) |=> regReadData[0]) else $error("clear-to-send delta missing");
  read_clear_a: assert property (regRead && regAddr == S1 && !loop1 && !$past(loop1) &&
    $stable(pins1) |=> !portModemIrq[0]) else $error("status read kept modem interrupt");
  irq_change_a: assert property (ier1 && next_ier1 &&
    !loop1 && !$past(loop1) && !$stable(pins1) |=> portModemIrq[0])
    else $error("modem change raised no interrupt");
  tx_free_a: assert property (!loop1 && !next_loop1 |=>
    port1SerialOut == $past(port1TxBit)) else $error("serial out does not follow transmit bit");
  cover property ($rose(reset_n));
  cover property (regWrite && regAddr == M1 && regWriteData[4]);
  cover property (portModemIrq[0] ##1 !portModemIrq[0]);
endmodule : umh_top_checker
bind umh_top umh_top_checker chk (.*);

// ==== testbench/tb.sv ====
// self-checking bench of the modem handshake block
`include "umh_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] d;
    logic [7:0] rb;
    logic       rts;
    logic       dtr;
  } umh_row_t;
  localparam logic [4:0] M1 = `UMH_P1_BASE + `UMH_OFS_MCR;
  localparam logic [4:0] M2 = `UMH_P2_BASE + `UMH_OFS_MCR;
  localparam logic [4:0] S1 = `UMH_P1_BASE + `UMH_OFS_MSR;
  localparam logic [4:0] S2 = `UMH_P2_BASE + `UMH_OFS_MSR;
  localparam logic [4:0] E1 = `UMH_P1_BASE + `UMH_OFS_IER;
  localparam logic [4:0] E2 = `UMH_P2_BASE + `UMH_OFS_IER;
  logic        clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, strap = 1'b1;
  logic [4:0]  regAddr = 5'h00;
  logic [7:0]  regWriteData = 8'h00, lvl = 8'h00, regReadData;
  logic        port1SerialIn = 1'b1, port2SerialOrInfraredIn = 1'b1;
  logic        port1TxBit = 1'b1, port2TxBit = 1'b1, irq, port1SendRequestN;
  logic        port1TerminalReadyN, port2SendRequestNOut, port2SendRequestNOe;
  logic        port2SendRequestNIn, port2TerminalReadyN, port1SerialOut;
  logic        port2SerialOrInfraredOut, port1RxBit, port2RxBit, configBaseStrap;
  logic        port1ClearToSendN, port1SetReadyN, port1CarrierDetectN, port1RingN;
  logic        port2ClearToSendN, port2SetReadyN, port2CarrierDetectN, port2RingN;
  logic [15:0] configIndexBase;
  logic [1:0]  portModemIrq;
  logic [3:0]  idle;
  int          n_mismatch = 0, n_checks = 0;
  // control writes and the pins they should give
  umh_row_t rows [9] = '{
    '{M1, 8'h02, 8'h02, 1'b0, 1'b1}, '{M1, 8'h01, 8'h01, 1'b1, 1'b0},
    '{M1, 8'h03, 8'h03, 1'b0, 1'b0}, '{M1, 8'hff, 8'h1f, 1'b1, 1'b1},
    '{M1, 8'h00, 8'h00, 1'b1, 1'b1}, '{M2, 8'h03, 8'h03, 1'b0, 1'b0},
    '{M2, 8'h13, 8'h13, 1'b1, 1'b1}, '{M2, 8'h02, 8'h02, 1'b0, 1'b1},
    '{M2, 8'h00, 8'h00, 1'b1, 1'b1}};
  assign idle = {port1SendRequestN, port1TerminalReadyN, port2TerminalReadyN, port2SendRequestNOe};
  // design, modem and clock
  umh_top dut (.*);
  umh_modem_model modem (.lvl(lvl), .strapLevel(strap), .rtsOut(port2SendRequestNOut),
    .rtsOe(port2SendRequestNOe), .rtsPin(port2SendRequestNIn),
    .p1PinsN({port1CarrierDetectN, port1RingN, port1SetReadyN, port1ClearToSendN}),
    .p2PinsN({port2CarrierDetectN, port2RingN, port2SetReadyN, port2ClearToSendN}));
  always #2 clk = ~clk;
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= v;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp, input string m);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regReadData, exp, m);
  endtask : rdc
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // hang guard
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  // main sequence: reset, table rows, then hand-written cases
  initial
  begin
    tick(16);
    chk(idle, 4'b1110, "reset pins");
    @(posedge clk) reset_n <= 1'b1;
    tick(2);
    chk({configBaseStrap, configIndexBase}, {1'b1, 16'h0370}, "strap high");
    rdc(`UMH_ADDR_CONFIG, 8'h01, "config");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      tick(1); // pins register the control value one edge after it lands
      if (rows[i].a == M1)
        chk({port1SendRequestN, port1TerminalReadyN}, {rows[i].rts, rows[i].dtr}, "p1");
      else
        chk({port2SendRequestNIn, port2TerminalReadyN}, {rows[i].rts, rows[i].dtr}, "p2");
      rdc(rows[i].a, rows[i].rb, "mcr readback");
    end
    // leaving loopback in the rows above left change bits behind
    rdc(S1, 8'h0f, "loop exit delta");
    rdc(S2, 8'h03, "loop exit delta");
    wr(E1, 8'h08);
    wr(E2, 8'h08);
    wr(`UMH_ADDR_IRQMASK, 8'h03);
    rdc(E2, 8'h08, "ier readback");
    rdc(`UMH_ADDR_IRQMASK, 8'h03, "mask readback");
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 4; s++)
      begin
        @(posedge clk) lvl[4*p+s] <= 1'b1;
        tick(2);
        chk(portModemIrq[p], 1'b1, "change irq");
        rdc(p ? S2 : S1, 8'h10 << s, "level");
        chk(portModemIrq[p], 1'b0, "irq withdrawn");
        @(posedge clk) lvl[4*p+s] <= 1'b0;
        rdc(p ? S2 : S1, 8'h01 << s, "delta");
        rdc(p ? S2 : S1, 8'h00, "delta cleared");
      end
    chk(irq, 1'b1, "irq line");
    wr(`UMH_ADDR_IRQSTAT, 8'h01);
    rdc(`UMH_ADDR_IRQSTAT, 8'h02, "w1c one bit");
    wr(`UMH_ADDR_IRQSTAT, 8'h02);
    chk(irq, 1'b0, "irq cleared");
    wr(`UMH_ADDR_IRQMASK, 8'h02);
    @(posedge clk) lvl[0] <= 1'b1;
    tick(2);
    chk(irq, 1'b0, "irq masked");
    wr(`UMH_ADDR_IRQMASK, 8'h03);
    chk(irq, 1'b1, "irq unmasked");
    wr(`UMH_ADDR_IRQSTAT, 8'h01);
    chk(irq, 1'b0, "irq cleared again");
    wr(E1, 8'h00);
    @(posedge clk) lvl[0] <= 1'b0;
    tick(2);
    chk(portModemIrq[0], 1'b0, "irq disabled");
    rdc(`UMH_ADDR_IRQSTAT, 8'h00, "no event when disabled");
    // transmit and receive paths while clear-to-send toggles
    for (int v = 0; v < 8; v++)
    begin
      @(posedge clk) {lvl[0], port1TxBit, port2TxBit} <= v[2:0];
      port1SerialIn <= v[0];
      port2SerialOrInfraredIn <= v[1];
      tick(1);
      chk({port1SerialOut, port2SerialOrInfraredOut, port1RxBit, port2RxBit},
          {v[1], v[0], v[0], v[1]}, "serial paths");
    end
    rdc(S1, 8'h11, "status after toggling");
    wr(M1, 8'h1f);
    @(posedge clk) port1TxBit <= 1'b0;
    tick(2);
    chk({port1SerialOut, port1RxBit}, 2'b10, "loopback serial");
    rdc(S1, 8'hf0, "loopback status");
    wr(M1, 8'h00);
    wr(5'h1f, 8'hff);
    rdc(5'h1f, 8'h00, "unmapped read");
    rdc(M1, 8'h00, "unmapped write ignored");
    // second reset with the strap low
    wr(M1, 8'h03);
    @(posedge clk) reset_n <= 1'b0;
    strap <= 1'b0;
    tick(2);
    chk(idle, 4'b1110, "mid-run reset pins");
    @(posedge clk) reset_n <= 1'b1;
    tick(2);
    chk({configBaseStrap, configIndexBase}, {1'b0, 16'h03f0}, "strap low");
    rdc(`UMH_ADDR_CONFIG, 8'h00, "config low");
    tally_and_finish();
  end
endmodule : tb
